/* hw/vsad_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module vsad_decoder
  import vsad_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [VSAD_ADDR_W-1:0] vme_addr,
  input wire logic [VSAD_AM_W-1:0] vme_am,
  input wire logic vme_as_n,
  input wire logic vme_lword_n,
  input wire logic local_ack_cycle_flag,
  input wire logic supervisory_only_strap,
  input wire logic short_address_strap,
  input wire logic [3:0] base_switch_top_nibble,
  input wire logic [3:0] base_switch_second_nibble,
  input wire logic [3:0] base_switch_third_nibble,
  input wire logic [3:0] base_switch_low_bits,
  output logic module_sel,
  output logic dma_sel,
  output logic scsi_ctl_sel
);
  // ***********************************************************************
  // state
  // ***********************************************************************
  typedef struct packed {
    logic [1:0] rst_sync;
    logic sel;
    logic dma;
    logic scsi;
  } vsad_state_t;

  vsad_state_t st_r;
  vsad_state_t st_nxt;
  logic rst_int_n;
  logic top_ok;
  logic second_ok;
  logic third_ok;
  logic low_ok;
  logic am_ok;
  logic hit;

  // function: modifier permitted by both straps
  function automatic logic vsad_am_allowed(input logic [5:0] am,
                                           input logic short_a,
                                           input logic sup_only);
    logic sup_hit;
    logic usr_hit;
    sup_hit = short_a ? (am == VSAD_AM_A16_SUP)
                      : (am == VSAD_AM_A24_SUP_DATA);
    usr_hit = short_a ? (am == VSAD_AM_A16_USR)
                      : (am == VSAD_AM_A24_USR_DATA);
    return sup_hit | (usr_hit & ~sup_only);
  endfunction

  assign rst_int_n = st_r.rst_sync[1];

  // ***********************************************************************
  // compare
  // ***********************************************************************
  // nibble and 3-bit low compares; bits below A9 take no part
  assign top_ok = vme_addr[VSAD_TOP_LSB+:4] == base_switch_top_nibble;
  assign second_ok = vme_addr[VSAD_SECOND_LSB+:4] ==
                     base_switch_second_nibble;
  assign third_ok = vme_addr[VSAD_THIRD_LSB+:4] ==
                    base_switch_third_nibble;
  assign low_ok = vme_addr[VSAD_LOW_LSB+:3] == base_switch_low_bits[3:1];
  assign am_ok = vsad_am_allowed(vme_am, short_address_strap,
                                 supervisory_only_strap);
  // width check: a hit needs lword_n high, so 32-bit longword transfers are not claimed
  assign hit = third_ok & low_ok & am_ok & ~local_ack_cycle_flag &
               (short_address_strap | (top_ok & second_ok)) &
               ~vme_as_n & vme_lword_n;

  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rst_sync = {st_r.rst_sync[0], 1'b1};
    st_nxt.sel = hit;
    st_nxt.dma = hit & ~vme_addr[VSAD_HALF_BIT];
    st_nxt.scsi = hit & vme_addr[VSAD_HALF_BIT];
    if (!rst_int_n) begin
      st_nxt.sel = 1'b0;
      st_nxt.dma = 1'b0;
      st_nxt.scsi = 1'b0;
    end
  end

  // registers; reset sync bit 0 takes constant 1, bit 1 takes bit 0
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign module_sel = st_r.sel;
  assign dma_sel = st_r.dma;
  assign scsi_ctl_sel = st_r.scsi;
endmodule
`default_nettype wire

/* hw/vsad_pkg.sv */
// Behaviour
// - compare A23-A20, A19-A16, A15-A12 with the top, second and third switches.
// - low switch compared to A11-A9 only; its lowest bit is ignored.
// - short-address strap drops the two top switches from the compare.
// - strap picks 24-bit or 16-bit decoding; only matching modifier class accepted.
// - supervisory strap limits access to supervisory modifier codes.
// - slave accepts word and byte transfers; masters use only those widths.
// - decoding suppressed during interrupt acknowledge cycles.
// - a match claims 512 bytes; bits below A9 skip the base compare.
// - lower 256 bytes select DMA, upper half selects SCSI and control register.
package vsad_pkg;
  // ***********************************************************************
  // address layout
  // ***********************************************************************
  localparam int VSAD_ADDR_W = 24;
  localparam int VSAD_AM_W = 6;
  localparam int VSAD_TOP_LSB = 20;
  localparam int VSAD_SECOND_LSB = 16;
  localparam int VSAD_THIRD_LSB = 12;
  localparam int VSAD_LOW_LSB = 9;
  localparam int VSAD_HALF_BIT = 8;
  // ***********************************************************************
  // address modifier codes
  // ***********************************************************************
  localparam logic [5:0] VSAD_AM_A24_SUP_DATA = 6'h3d;
  localparam logic [5:0] VSAD_AM_A24_USR_DATA = 6'h39;
  localparam logic [5:0] VSAD_AM_A16_SUP = 6'h2d;
  localparam logic [5:0] VSAD_AM_A16_USR = 6'h29;
endpackage

/* tb/vsad_decoder_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module vsad_chk(input wire logic ref_clk,rst_n,vme_as_n,vme_lword_n,
  input wire logic local_ack_cycle_flag,short_address_strap,module_sel,
  input wire logic dma_sel,scsi_ctl_sel,input wire logic [23:0] vme_addr,
  input wire logic [5:0] vme_am);
  default clocking @(posedge ref_clk);endclocking
  default disable iff(!rst_n);
  sequence s_up;$rose(vme_as_n);endsequence
  a_sel_as:assert property(module_sel|->!$past(vme_as_n))else $error("as");
  a_no_iack:assert property(module_sel|->!$past(local_ack_cycle_flag))
    else $error("iack");
  a_word_only:assert property(module_sel|->$past(vme_lword_n))
    else $error("lw");
  a_dma_low:assert property(dma_sel|->module_sel&&!$past(vme_addr[8]))
    else $error("dma");
  a_scsi_up:assert property(scsi_ctl_sel|->$past(vme_addr[8]))
    else $error("scsi");
  a_one_tgt:assert property(module_sel|->dma_sel^scsi_ctl_sel)
    else $error("tgt");
  a_as_drop:assert property(s_up|=>!module_sel)else $error("drop");
  a_am_class:assert property(module_sel|->$past(vme_am[5:3])==
    ($past(short_address_strap)?3'h5:3'h7))else $error("am");
endmodule
bind vsad_decoder vsad_chk vsad_chk_inst(.*);
`default_nettype wire

/* tb/vsad_mm.sv */
`timescale 1ns/1ps
`default_nettype none
module vsad_mm(input wire logic ref_clk,output logic [23:0] vme_addr=0,
  output logic [5:0] vme_am=0,output logic vme_as_n=1);
  // released bus shows inverted address, never a stale copy
  task rel;@(posedge ref_clk){vme_addr,vme_as_n}<={~vme_addr,1'b1};endtask
  task cyc(input logic [23:0] a,input logic [5:0] m);
    @(posedge ref_clk){vme_addr,vme_am,vme_as_n}<={a,m,1'b0};
    repeat(2)@(posedge ref_clk);#1;
  endtask
endmodule
`default_nettype wire

/* tb/vsad_decoder_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module vsad_decoder_tb_top;
  logic ref_clk=0,rst_n=0;logic [3:0] c=1;int num_errors=0,n_checks=0;
  wire module_sel,dma_sel,scsi_ctl_sel,vme_as_n;wire [23:0] vme_addr;
  wire [5:0] vme_am;
  always #25 ref_clk=~ref_clk;
  vsad_mm vsad_mm_inst(.*);
  // base a5_3_4 window; low switch odd so its ignored bit is exercised
  vsad_decoder vsad_decoder_inst(.*,.supervisory_only_strap(c[3]),
    .short_address_strap(c[2]),.local_ack_cycle_flag(c[1]),
    .vme_lword_n(c[0]),.base_switch_top_nibble(4'ha),
    .base_switch_second_nibble(4'h5),.base_switch_third_nibble(4'h3),
    .base_switch_low_bits(4'h5));
  task chk(input logic [2:0] s,e);
    n_checks++;
    if(s!==e)begin num_errors++;$display("[FAIL] %0t %h %h",$time,s,e);end
  endtask
  task t(input logic [23:0] a,input logic [5:0] m,input logic [3:0] k,
    input logic [2:0] e);
    vsad_mm_inst.rel;
    c<=k;
    vsad_mm_inst.cyc(a,m);
    chk({module_sel,dma_sel,scsi_ctl_sel},e);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d",n_checks,num_errors);
    if(num_errors==0&&n_checks>0)$display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat(20)@(posedge ref_clk);
    rst_n<=1;
    t(24'ha53400,6'h3d,4'h1,3'h6);
    t(24'ha535ff,6'h39,4'h1,3'h5);
    t(24'ha53600,6'h3d,4'h1,3'h0);
    t(24'ha43400,6'h3d,4'h1,3'h0);
    t(24'ha53400,6'h2d,4'h1,3'h0);
    t(24'ha53400,6'h3d,4'h3,3'h0);
    t(24'ha53400,6'h3d,4'h0,3'h0);
    t(24'ha53400,6'h39,4'h9,3'h0);
    t(24'h003400,6'h29,4'h5,3'h6);
    print_verdict;
  end
endmodule
`default_nettype wire
